// ==== inc/tlra_if.sv ====
`timescale 1ns/100ps
interface tlra_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  wire  scl = (~scl_oe_n & ~scl_o) ? 1'b0 : 1'b1;
  wire  sda = (~sda_m_oe_n & ~sda_m_o) | (~sda_s_oe_n & ~sda_s_o) ? 1'b0 : 1'b1;

  modport master (output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n,
                  input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface

// ==== inc/tlra_pkg.sv ====
package tlra_pkg;
  // ****************************************
  // Bus pattern and pointers
  // ****************************************
  localparam logic [3:0]  TLRA_ADDR_FIXED    = 4'h9;
  localparam logic [7:0]  TLRA_PTR_LOWER     = 8'h02;
  localparam logic [7:0]  TLRA_PTR_UPPER     = 8'h03;
  localparam logic [7:0]  TLRA_PTR_ST_LOWER  = 8'h12;
  localparam logic [7:0]  TLRA_PTR_ST_UPPER  = 8'h13;
  // ****************************************
  // Reset and shipping values
  // ****************************************
  localparam logic [15:0] TLRA_SHIP_LOWER    = 16'h4B00;
  localparam logic [15:0] TLRA_SHIP_UPPER    = 16'h5000;
  localparam logic [7:0]  TLRA_PTR_RESET     = 8'h00;
  localparam logic [1:0]  TLRA_RES_RESET     = 2'h0;
  localparam int          TLRA_SIGN_BIT      = 15;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          TLRA_CLK_MHZ       = 50;
  localparam int          TLRA_PROG_US       = 5000;
  localparam int          TLRA_PROG_CYC      = TLRA_PROG_US * TLRA_CLK_MHZ;
  localparam int          TLRA_LINK_HALF     = 4;
  // ****************************************
  // Host APB register map
  // ****************************************
  localparam logic [7:0]  TLRA_REG_CMD       = 8'h00;
  localparam logic [7:0]  TLRA_REG_DATA      = 8'h04;
  localparam logic [7:0]  TLRA_REG_STATUS    = 8'h08;
  localparam logic [7:0]  TLRA_REG_RDATA     = 8'h0C;
  localparam int          TLRA_CMD_GO        = 0;
  localparam int          TLRA_CMD_READ      = 1;
  localparam int          TLRA_CMD_SETPTR    = 2;
  localparam int          TLRA_CMD_ADDR_LSB  = 4;
  localparam int          TLRA_CMD_PTR_LSB   = 8;

  // Keep the bits used at the chosen resolution
  function automatic logic [15:0] tlra_mask(input logic [15:0] v, input logic [1:0] res);
    logic [15:0] m;
    m = 16'hFF80 >> 0;
    case (res)
      2'h0:    m = 16'hFF80;
      2'h1:    m = 16'hFFC0;
      2'h2:    m = 16'hFFE0;
      default: m = 16'hFFF0;
    endcase
    return v & m;
  endfunction
endpackage

// ==== test/temp_limit_register_access_tb.sv ====
`timescale 1ns/100ps
module temp_limit_register_access_tb;
  import tlra_pkg::*;
  typedef struct {int kind; logic [15:0] v;} tlra_note_t;
  logic        mclk_i = 0, rst_n_i = 0, por_n_i = 0;
  logic        psel = 0, penable = 0, pwrite = 0, chk = 0, look = 0;
  logic        lck = 0, lkd = 0, pready, pslverr, busy, above, below, ready;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [1:0]  res = 0;
  logic [15:0] temp = 0, v, x;
  logic [15:0] tv [6] = '{16'h3000, 16'h2000, 16'h1800, 16'h1000, 16'h0800, 16'hF000};
  logic [1:0]  ev [6] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1};
  tlra_note_t  q [$];
  tlra_note_t  n;
  int          n_mismatch = 0, n_compared = 0, seed = 86273;

  always #10 mclk_i = ~mclk_i;

  tlra_if bus_if ();
  tlra_host tlra_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.master),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tlra_device #(.PROG_CYC(4000)) tlra_device_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .por_n_i(por_n_i), .bus(bus_if.slave), .address_select_pins_i(3'h5),
    .resolution_field_i(res), .reversible_lock_bit_i(lck), .permanent_lockdown_bit_i(lkd),
    .temperature_value_bits_i(temp), .stored_copy_busy_flag_o(busy),
    .above_upper_o(above), .below_lower_o(below), .ready_o(ready));
  tlra_properties tlra_properties_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .scl_o(bus_if.scl_o), .scl_oe_n(bus_if.scl_oe_n), .sda_m_o(bus_if.sda_m_o),
    .sda_m_oe_n(bus_if.sda_m_oe_n), .sda_s_o(bus_if.sda_s_o),
    .sda_s_oe_n(bus_if.sda_s_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));

  // ****
  // Compare and report
  // ****
  task cmp_data(input string what, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %0s expected %h seen %h", what, e, s);
    end
  endtask
  task cmp_flag(input string what, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %0s expected %b seen %b", what, e, s);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    if ((chk && psel && penable && pready === 1'b1) || look) begin
      if (q.size() == 0) begin
        cmp_flag("note queue", 1'b1, 1'b0);
      end else begin
        n = q.pop_front();
        case (n.kind)
          0: cmp_data("limit", n.v, prdata[15:0]);
          1: cmp_flag("nack", n.v[0], prdata[1]);
          2: cmp_flag("pslverr", n.v[0], pslverr);
          default: cmp_data("alarm", n.v, {14'h0, above, below});
        endcase
      end
    end
  end

  // ****
  // Bus tasks
  // ****
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge mclk_i) penable <= 1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rdat = prdata;
    psel <= 0;
    penable <= 0;
    chk <= 0;
    @(posedge mclk_i);
  endtask
  task cmd(input logic [2:0] f, input logic [7:0] p, input logic [2:0] pins);
    apb(1, TLRA_REG_CMD, {16'h0, p, 1'b0, pins, 1'b0, f}, 0);
    rdat = 32'h1;
    while (rdat[0] !== 1'b0) apb(0, TLRA_REG_STATUS, 32'h0, 0);
  endtask
  task wr(input logic [7:0] p, input logic [15:0] d);
    apb(1, TLRA_REG_DATA, {16'h0, d}, 0);
    cmd(3'h1, p, 3'h5);
  endtask
  task rd(input logic [7:0] p, input logic [15:0] e);
    cmd(3'h5, p, 3'h5);
    cmd(3'h3, p, 3'h5);
    q.push_back('{0, e});
    apb(0, TLRA_REG_RDATA, 32'h0, 1);
  endtask
  task nk(input logic e);
    q.push_back('{1, {15'h0, e}});
    apb(0, TLRA_REG_STATUS, 32'h0, 1);
  endtask
  task rst(input logic p);
    rst_n_i <= 0;
    por_n_i <= p;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1;
    por_n_i <= 1;
    repeat (3) @(posedge mclk_i);
  endtask
  function automatic logic [15:0] msk(input logic [1:0] r);
    return ~(16'h007F >> r);
  endfunction

  // ****
  // Scenarios
  // ****
  initial begin
    rst(0);
    rd(TLRA_PTR_LOWER, TLRA_SHIP_LOWER);
    rd(TLRA_PTR_UPPER, TLRA_SHIP_UPPER);
    $display("test power_up done");
    for (int r = 0; r < 4; r++) begin
      v = $random(seed);
      res <= r[1:0];
      wr(TLRA_PTR_LOWER, v);
      rd(TLRA_PTR_LOWER, v & msk(r[1:0]));
    end
    res <= 2'h0;
    rd(TLRA_PTR_LOWER, v & msk(2'h0));
    $display("test resolution done");
    wr(TLRA_PTR_LOWER, 16'h1000);
    wr(TLRA_PTR_UPPER, 16'h2000);
    for (int i = 0; i < 6; i++) begin
      temp <= tv[i];
      repeat (4) @(posedge mclk_i);
      q.push_back('{3, {14'h0, ev[i]}});
      look <= 1;
      @(posedge mclk_i) look <= 0;
    end
    $display("test alarms done");
    for (int k = 0; k < 2; k++) begin
      {lkd, lck} <= k ? 2'h2 : 2'h1;
      wr(TLRA_PTR_LOWER, 16'h7F80);
      nk(1'b0);
      rd(TLRA_PTR_LOWER, 16'h1000);
    end
    {lkd, lck} <= 2'h0;
    $display("test locks done");
    x = 16'hE480;
    wr(TLRA_PTR_ST_LOWER, x);
    wr(TLRA_PTR_LOWER, 16'h0A00);
    nk(1'b0);
    rd(TLRA_PTR_LOWER, 16'h1000);
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) @(posedge mclk_i);
    rst(1);
    rd(TLRA_PTR_LOWER, x);
    rd(TLRA_PTR_UPPER, TLRA_SHIP_UPPER);
    $display("test stored_copy done");
    cmd(3'h3, TLRA_PTR_LOWER, 3'h2);
    nk(1'b1);
    q.push_back('{2, 16'h1});
    apb(0, 8'h10, 32'h0, 1);
    $display("test address done");
    rst(0);
    rd(TLRA_PTR_LOWER, TLRA_SHIP_LOWER);
    $display("test power_on done");
    complete_run;
  end

  initial begin
    #1800000;
    n_mismatch++;
    complete_run;
  end
endmodule

// ==== test/tlra_properties.sv ====
`timescale 1ns/100ps
// ****
// Link checks
// ****
module tlra_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  sequence s_low_phase;
    (!scl) [*4] ##[1:12] scl;
  endsequence

  AST_RESET_QUIET: assert property ($rose(rst_n_i) |->
    (scl_oe_n && sda_m_oe_n && sda_s_oe_n) [*2])
    else $error("link not idle after reset");
  AST_DEV_SDA_ON_LOW: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("device data changed while clock high");
  AST_NO_DEV_CONDITION: assert property (
    ($changed(sda) && scl && $past(scl)) |-> ($changed(sda_m_oe_n) || $changed(sda_m_o)))
    else $error("data line moved by device while clock high");
  AST_STOP_RELEASED: assert property (s_stop |=> sda_s_oe_n [*4])
    else $error("device drives after stop");
  AST_START_CLOCKS: assert property (s_start |-> ##[1:16] !scl)
    else $error("no clock after start");
  AST_SCL_LOW_PHASE: assert property ($fell(scl) |-> s_low_phase)
    else $error("clock low phase out of range");
  AST_SCL_HIGH_PHASE: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  AST_ACK_HELD: assert property (($rose(scl) && !sda_s_oe_n) |-> !sda_s_oe_n [*4])
    else $error("device bit not held through clock high");
endmodule

// ==== verilog/tlra_device.sv ====
`timescale 1ns/100ps
// Contract
// - Busy, lock or lockdown discards limit writes
// - Incomplete two-byte writes leave limit unchanged
// - Locked writes still acknowledge data bytes
// - Busy-discarded writes still acknowledge data bytes
// - Pointer 02h lower, 03h upper limit
// - Pointer stays on written limit register
// - Address 1001AAA plus direction bit acknowledged
// - Read sends upper byte then lower
// - Master NACK ends read, line released
// - Master ACK after lower byte repeats register
// - Reset loads volatile limits from stored copies
// - Comparisons use volatile limits only
// - Software keeps upper above lower
// - Limits are 16-bit twos complement
// - Writes mask bits below chosen resolution
// - Reads return masked resolution bits
// - Stored copies survive reset, self-timed program
// - Write: address, pointer, two data bytes
// - Stored copies at pointers 12h and 13h
// - Stop starts programming; repeated Start aborts
// - Stored copies ship as 4B00h, 5000h
module tlra_device
  import tlra_pkg::*;
#(
  parameter int PROG_CYC = TLRA_PROG_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        por_n_i,
  tlra_if.slave            bus,
  input  wire logic [2:0]  address_select_pins_i,
  input  wire logic [1:0]  resolution_field_i,
  input  wire logic        reversible_lock_bit_i,
  input  wire logic        permanent_lockdown_bit_i,
  input  wire logic [15:0] temperature_value_bits_i,
  output logic             stored_copy_busy_flag_o,
  output logic             above_upper_o,
  output logic             below_lower_o,
  output logic             ready_o
);
  typedef enum logic [5:0] {
    TLRA_S_IDLE = 6'b000001,
    TLRA_S_RX   = 6'b000010,
    TLRA_S_ACK  = 6'b000100,
    TLRA_S_TX   = 6'b001000,
    TLRA_S_MACK = 6'b010000,
    TLRA_S_SKIP = 6'b100000
  } tlra_st_t;

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  logic [1:0]  scl_sy;
  logic [1:0]  sda_sy;
  logic        scl_d;
  logic        sda_d;
  always_ff @(posedge mclk_i) begin
    scl_sy <= {scl_sy[0], bus.scl};
    sda_sy <= {sda_sy[0], bus.sda};
    scl_d  <= scl_sy[1];
    sda_d  <= sda_sy[1];
  end
  wire scl_rise = scl_sy[1] & ~scl_d;
  wire scl_fall = ~scl_sy[1] & scl_d;
  wire start_c  = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
  wire stop_c   = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] alarm_lower_bound;
  logic [15:0] alarm_upper_bound;
  logic [15:0] stored_lower_bound;
  logic [15:0] stored_upper_bound;
  logic [7:0]  ptr;
  logic        loaded;
  tlra_st_t    st;
  logic [2:0]  bitc;
  logic [7:0]  shreg;
  logic [1:0]  bytec;
  logic        rd_mode;
  logic        rd_lo;
  logic        addr_ok;
  logic [7:0]  hi_byte;
  logic        wr_full;
  logic [15:0] wr_val;
  logic        pend;
  logic [7:0]  pend_ptr;
  logic [15:0] pend_val;
  logic [31:0] prog_cnt;
  logic        sda_drv;
  logic [15:0] cur_val;

  wire locked   = reversible_lock_bit_i | permanent_lockdown_bit_i;
  wire is_limit = (ptr == TLRA_PTR_LOWER) || (ptr == TLRA_PTR_UPPER);
  wire is_store = (ptr == TLRA_PTR_ST_LOWER) || (ptr == TLRA_PTR_ST_UPPER);

  function automatic logic [15:0] sel_reg(input logic [7:0] p);
    case (p)
      TLRA_PTR_LOWER:    sel_reg = tlra_mask(alarm_lower_bound, resolution_field_i);
      TLRA_PTR_UPPER:    sel_reg = tlra_mask(alarm_upper_bound, resolution_field_i);
      TLRA_PTR_ST_LOWER: sel_reg = tlra_mask(stored_lower_bound, resolution_field_i);
      TLRA_PTR_ST_UPPER: sel_reg = tlra_mask(stored_upper_bound, resolution_field_i);
      default:           sel_reg = 16'h0000;
    endcase
  endfunction
  assign cur_val = sel_reg(ptr);

  // ****************************************
  // Serial protocol engine
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !loaded) begin
      st      <= TLRA_S_IDLE;
      bitc    <= 3'h0;
      shreg   <= 8'h00;
      bytec   <= 2'h0;
      rd_mode <= 1'b0;
      rd_lo   <= 1'b0;
      addr_ok <= 1'b0;
      hi_byte <= 8'h00;
      wr_full <= 1'b0;
      wr_val  <= 16'h0000;
      sda_drv <= 1'b0;
      if (!rst_n_i) ptr <= TLRA_PTR_RESET;
    end else if (start_c || stop_c) begin
      st      <= start_c ? TLRA_S_RX : TLRA_S_IDLE;
      bitc    <= 3'h0;
      bytec   <= 2'h0;
      rd_mode <= 1'b0;
      wr_full <= 1'b0;
      sda_drv <= 1'b0;
    end else begin
      wr_full <= 1'b0;
      unique case (st)
        TLRA_S_IDLE: sda_drv <= 1'b0;
        TLRA_S_RX: if (scl_rise) begin
          shreg <= {shreg[6:0], sda_sy[1]};
          bitc  <= bitc + 3'h1;
          if (bitc == 3'h7) st <= TLRA_S_ACK;
        end
        TLRA_S_ACK: begin
          if (scl_fall && !sda_drv) begin
            sda_drv <= 1'b1;
            if (bytec == 2'h0) begin
              addr_ok <= (shreg[7:4] == TLRA_ADDR_FIXED) &&
                         (shreg[3:1] == address_select_pins_i);
              rd_mode <= shreg[0];
              if ((shreg[7:4] != TLRA_ADDR_FIXED) || (shreg[3:1] != address_select_pins_i))
                sda_drv <= 1'b0;
            end else if (bytec == 2'h1) begin
              ptr <= shreg;
            end else if (bytec == 2'h2) begin
              hi_byte <= shreg;
            end else begin
              wr_val  <= {hi_byte, shreg};
              wr_full <= 1'b1;
            end
            // Data bytes acked even when discarded
          end else if (scl_fall && sda_drv) begin
            sda_drv <= 1'b0;
            bitc    <= 3'h0;
            if (bytec != 2'h3) bytec <= bytec + 2'h1;
            if (rd_mode && bytec == 2'h0) begin
              st      <= TLRA_S_TX;
              rd_lo   <= 1'b0;
              shreg   <= cur_val[15:8];
              sda_drv <= ~cur_val[15];
            end else begin
              st <= TLRA_S_RX; // Extra bytes rewrite low byte under held upper byte
            end
          end else if (scl_fall) begin
            st <= TLRA_S_SKIP;
          end
          if (bytec == 2'h0 && scl_fall && sda_drv && !addr_ok) st <= TLRA_S_SKIP;
        end
        TLRA_S_TX: if (scl_fall) begin
          bitc <= bitc + 3'h1;
          if (bitc == 3'h7) begin
            sda_drv <= 1'b0;
            st      <= TLRA_S_MACK;
          end else begin
            sda_drv <= ~shreg[6];
            shreg   <= {shreg[6:0], 1'b0};
          end
        end
        TLRA_S_MACK: if (scl_rise) begin
          if (sda_sy[1]) begin
            st <= TLRA_S_SKIP;
          end else begin
            rd_lo <= ~rd_lo;
            bitc  <= 3'h0;
            // Upper again after lower
            shreg <= rd_lo ? cur_val[15:8] : cur_val[7:0];
          end
        end else if (scl_fall) begin
          st      <= TLRA_S_TX;
          sda_drv <= ~shreg[7];
        end
        TLRA_S_SKIP: sda_drv <= 1'b0;
        default: st <= TLRA_S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Volatile limits
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      alarm_lower_bound <= 16'h0000;
      alarm_upper_bound <= 16'h0000;
      loaded            <= 1'b0;
    end else if (!loaded) begin
      alarm_lower_bound <= stored_lower_bound;
      alarm_upper_bound <= stored_upper_bound;
      loaded            <= 1'b1;
    end else if (wr_full && is_limit && !stored_copy_busy_flag_o && !locked) begin
      if (ptr == TLRA_PTR_LOWER)
        alarm_lower_bound <= tlra_mask(wr_val, resolution_field_i);
      else
        alarm_upper_bound <= tlra_mask(wr_val, resolution_field_i);
    end
  end

  // ****************************************
  // Stored copies and programming timer
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!por_n_i) begin
      stored_lower_bound <= TLRA_SHIP_LOWER;
      stored_upper_bound <= TLRA_SHIP_UPPER;
    end else if (stored_copy_busy_flag_o && prog_cnt == 32'h1) begin
      if (pend_ptr == TLRA_PTR_ST_LOWER) stored_lower_bound <= pend_val;
      else stored_upper_bound <= pend_val;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pend     <= 1'b0;
      pend_ptr <= 8'h00;
      pend_val <= 16'h0000;
    end else if (wr_full && is_store && !stored_copy_busy_flag_o && !locked) begin
      pend     <= 1'b1;
      pend_ptr <= ptr;
      pend_val <= tlra_mask(wr_val, resolution_field_i);
    end else if (stop_c || start_c) begin
      pend <= 1'b0; // Repeated start aborts
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      stored_copy_busy_flag_o <= 1'b0;
      prog_cnt                <= 32'h0;
    end else if (stop_c && pend) begin
      stored_copy_busy_flag_o <= 1'b1;
      prog_cnt                <= 32'(PROG_CYC);
    end else if (stored_copy_busy_flag_o) begin
      prog_cnt <= prog_cnt - 32'h1;
      if (prog_cnt == 32'h1) stored_copy_busy_flag_o <= 1'b0;
    end
  end

  // ****************************************
  // Comparison and outputs
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !loaded) begin
      above_upper_o <= 1'b0;
      below_lower_o <= 1'b0;
      ready_o       <= 1'b0;
    end else begin
      ready_o       <= 1'b1;
      above_upper_o <= $signed(temperature_value_bits_i) >= $signed(alarm_upper_bound);
      below_lower_o <= $signed(temperature_value_bits_i) < $signed(alarm_lower_bound);
    end
  end

  // Open-drain data line: enable low pulls low
  assign bus.sda_s_o    = 1'b0;
  assign bus.sda_s_oe_n = ~sda_drv;
endmodule

// ==== verilog/tlra_host.sv ====
`timescale 1ns/100ps
// Bus master: APB-commanded limit writes and reads
module tlra_host
  import tlra_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  tlra_if.master           bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef enum logic [3:0] {
    TLRA_H_IDLE = 4'b0001,
    TLRA_H_RUN  = 4'b0010,
    TLRA_H_STOP = 4'b0100,
    TLRA_H_DONE = 4'b1000
  } tlra_hst_t;

  logic [15:0] cmd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        nack;
  tlra_hst_t   st;
  logic [5:0]  step;
  logic [1:0]  phase;
  logic [3:0]  div;
  logic [1:0]  sda_sy;
  logic [5:0]  nbits;
  logic [35:0] frame;

  // ****************************************
  // APB slave, one wait-free access phase
  // ****************************************
  wire go = psel && penable && pwrite && (paddr == TLRA_REG_CMD) && !busy;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd     <= 16'h0000;
      wdata   <= 16'h0000;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {TLRA_REG_CMD, TLRA_REG_DATA,
                                                    TLRA_REG_STATUS, TLRA_REG_RDATA});
      if (psel && penable && pready && pwrite && paddr == TLRA_REG_CMD) cmd <= pwdata[15:0];
      if (psel && penable && pready && pwrite && paddr == TLRA_REG_DATA) wdata <= pwdata[15:0];
      case (paddr)
        TLRA_REG_CMD:    prdata <= {16'h0, cmd};
        TLRA_REG_DATA:   prdata <= {16'h0, wdata};
        TLRA_REG_STATUS: prdata <= {30'h0, nack, busy};
        TLRA_REG_RDATA:  prdata <= {16'h0, rdata};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Bit sequencer: frame of bits, MSB first
  // ****************************************
  always_ff @(posedge mclk_i) begin
    sda_sy <= {sda_sy[0], bus.sda};
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st    <= TLRA_H_IDLE;
      busy  <= 1'b0;
      nack  <= 1'b0;
      rdata <= 16'h0000;
      step  <= 6'h0;
      phase <= 2'h0;
      div   <= 4'h0;
      nbits <= 6'h0;
      frame <= 36'h0;
      bus.scl_o      <= 1'b0;
      bus.scl_oe_n   <= 1'b1;
      bus.sda_m_o    <= 1'b0;
      bus.sda_m_oe_n <= 1'b1;
    end else begin
      unique case (st)
        TLRA_H_IDLE: if (psel && penable && pready && pwrite && paddr == TLRA_REG_CMD &&
                         pwdata[TLRA_CMD_GO]) begin
          busy <= 1'b1;
          nack <= 1'b0;
          st   <= TLRA_H_RUN;
          step <= 6'h0;
          div  <= 4'h0;
          phase <= 2'h0;
          bus.sda_m_oe_n <= 1'b0; // Start: pull data low with clock high
          if (pwdata[TLRA_CMD_READ]) begin
            frame <= {TLRA_ADDR_FIXED, pwdata[6:4], 1'b1, 1'b1, 8'hFF, 1'b0, 8'hFF, 1'b1, 9'h0};
            nbits <= 6'd27;
          end else if (pwdata[TLRA_CMD_SETPTR]) begin
            frame <= {TLRA_ADDR_FIXED, pwdata[6:4], 1'b0, 1'b1, pwdata[15:8], 1'b1, 18'h0};
            nbits <= 6'd18;
          end else begin
            frame <= {TLRA_ADDR_FIXED, pwdata[6:4], 1'b0, 1'b1, pwdata[15:8], 1'b1,
                      wdata[15:8], 1'b1, wdata[7:0], 1'b1};
            nbits <= 6'd36;
          end
        end
        TLRA_H_RUN: begin
          div <= div + 4'h1;
          if (div == 4'(TLRA_LINK_HALF - 1)) begin
            div   <= 4'h0;
            phase <= phase + 2'h1;
            case (phase)
              2'h0: bus.scl_oe_n <= 1'b0;
              2'h1: bus.sda_m_oe_n <= frame[35];
              2'h2: bus.scl_oe_n <= 1'b1;
              default: begin
                // Sample on the high clock half
                if (step == 6'd8 || step == 6'd17 || step == 6'd26 || step == 6'd35) begin
                  if (sda_sy[1] && frame[35] && step != 6'd26) nack <= 1'b1;
                end else if (step > 6'd8) begin
                  rdata <= {rdata[14:0], sda_sy[1]};
                end
                frame <= {frame[34:0], 1'b0};
                step  <= step + 6'h1;
                if (step + 6'h1 == nbits) st <= TLRA_H_STOP;
              end
            endcase
          end
        end
        TLRA_H_STOP: begin
          div <= div + 4'h1;
          if (div == 4'(TLRA_LINK_HALF - 1)) begin
            div   <= 4'h0;
            phase <= phase + 2'h1;
            case (phase)
              2'h0: bus.scl_oe_n <= 1'b0;
              2'h1: bus.sda_m_oe_n <= 1'b0;
              2'h2: bus.scl_oe_n <= 1'b1;
              default: begin
                bus.sda_m_oe_n <= 1'b1; // Stop: release data with clock high
                st <= TLRA_H_DONE;
              end
            endcase
          end
        end
        TLRA_H_DONE: begin
          busy <= 1'b0;
          st   <= TLRA_H_IDLE;
        end
        default: st <= TLRA_H_IDLE;
      endcase
    end
  end
endmodule
